/* logic/sec_err_pkg.sv */
`default_nettype none
package sec_err_pkg;
	localparam logic [11:0] SEVERITY_OFFSET   = 12'h134;
	localparam logic [11:0] CAP_CTRL_OFFSET   = 12'h138;
	localparam logic [31:0] SEVERITY_RESET    = 32'h00001340;
	localparam logic [31:0] SEVERITY_WMASK    = 32'h00003FEE;
	// Errors the bridge really reports; the PCI-X bits are storage only
	localparam logic [31:0] REPORTED_MASK     = 32'h00001E8C;
	localparam logic [31:0] CAP_CTRL_RESET    = 32'h00000000;
	localparam int          POINTER_WIDTH     = 5;
	localparam int          ERROR_BITS        = 14;
endpackage : sec_err_pkg
`default_nettype wire

/* logic/sec_err_if.sv */
`default_nettype none
interface sec_err_if;
	logic [13:0] event_hit;
	logic        load_pointer;
	logic [4:0]  pointer_value;
	modport pick (input event_hit, output load_pointer, output pointer_value);
	modport user (output event_hit, input load_pointer, input pointer_value);
endinterface : sec_err_if
`default_nettype wire

/* logic/first_error_pick.sv */
`default_nettype none
// Picks the lowest bit among simultaneous new unmasked errors.
module first_error_pick (
	sec_err_if.pick lane
);
	always_comb begin
		lane.load_pointer  = |lane.event_hit;
		lane.pointer_value = 5'h00;
		for (int i = sec_err_pkg::ERROR_BITS - 1; i >= 0; i--) begin
			if (lane.event_hit[i]) begin
				lane.pointer_value = 5'(i);
			end
		end
	end
endmodule : first_error_pick
`default_nettype wire

/* logic/secondary_error_severity_pointer.sv */
`default_nettype none
module secondary_error_severity_pointer (
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        LINK_RESET_INPUT_N,
	input  wire logic        GLOBAL_RESET_INPUT_N,
	input  wire logic [11:0] CFG_ADDR,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic [31:0] CFG_WDATA,
	input  wire logic [3:0]  CFG_BE,
	input  wire logic [31:0] ERROR_EVENT,
	input  wire logic [31:0] ERROR_MASK,
	input  wire logic [31:0] ERROR_STATUS,
	output logic      [31:0] CFG_RDATA,
	output logic             CFG_RVALID,
	output logic             ERR_FATAL_SEND,
	output logic             ERR_NONFATAL_SEND
);
	logic        fundamental_reset_n;
	logic [31:0] severity;
	logic [31:0] next_severity;
	logic [4:0]  first_error_pointer;
	logic [4:0]  next_first_error_pointer;
	logic [31:0] next_rdata;
	logic        next_fatal;
	logic        next_nonfatal;
	logic [31:0] live;
	logic [31:0] byte_mask;
	logic        status_busy;

	sec_err_if lane ();

	// Address match, shared by the write path and its checks
	function automatic logic hits(input logic [11:0] addr, input logic [11:0] offset);
		return addr == offset;
	endfunction : hits

	// Any of the three reset inputs pulls the sticky domain down
	assign fundamental_reset_n = RST_N & LINK_RESET_INPUT_N & GLOBAL_RESET_INPUT_N;

	// Only unmasked, really reported errors count
	assign live = ERROR_EVENT & ~ERROR_MASK & sec_err_pkg::REPORTED_MASK;
	// Status already holding an unmasked error freezes the pointer
	assign status_busy = |(ERROR_STATUS & ~ERROR_MASK & sec_err_pkg::REPORTED_MASK);
	assign lane.event_hit = status_busy ? 14'h0000 : live[13:0];

	first_error_pick pick (
		.lane (lane)
	);

	for (genvar b = 0; b < 4; b++) begin : g_be
		assign byte_mask[8*b+7:8*b] = {8{CFG_BE[b]}};
	end

	always_comb begin
		next_severity            = severity;
		next_first_error_pointer = first_error_pointer;
		next_rdata               = 32'h00000000;
		if (CFG_WR && hits(CFG_ADDR, sec_err_pkg::SEVERITY_OFFSET)) begin
			next_severity = (severity & ~(sec_err_pkg::SEVERITY_WMASK & byte_mask))
				| (CFG_WDATA & sec_err_pkg::SEVERITY_WMASK & byte_mask);
		end
		if (lane.load_pointer) begin
			next_first_error_pointer = lane.pointer_value;
		end
		if (CFG_RD) begin
			case (CFG_ADDR)
				sec_err_pkg::SEVERITY_OFFSET: next_rdata = severity & sec_err_pkg::SEVERITY_WMASK;
				sec_err_pkg::CAP_CTRL_OFFSET: next_rdata = {27'h0000000, first_error_pointer};
				default:                      next_rdata = 32'h00000000;
			endcase
		end
		next_fatal    = |(live & severity);
		next_nonfatal = |(live & ~severity);
	end

	always_ff @(posedge MCLK or negedge fundamental_reset_n) begin
		if (!fundamental_reset_n) begin
			severity            <= sec_err_pkg::SEVERITY_RESET;
			first_error_pointer <= sec_err_pkg::CAP_CTRL_RESET[4:0];
			CFG_RDATA           <= 32'h00000000;
			CFG_RVALID          <= 1'b0;
			ERR_FATAL_SEND      <= 1'b0;
			ERR_NONFATAL_SEND   <= 1'b0;
		end else begin
			severity            <= next_severity;
			first_error_pointer <= next_first_error_pointer;
			CFG_RDATA           <= next_rdata;
			CFG_RVALID          <= CFG_RD;
			ERR_FATAL_SEND      <= next_fatal;
			ERR_NONFATAL_SEND   <= next_nonfatal;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!fundamental_reset_n);

	fatal_path_a: assert property (|(live & severity) |=> ERR_FATAL_SEND)
		else $error("fatal message missing");
	nonfatal_path_a: assert property (|(live & ~severity) |=> ERR_NONFATAL_SEND)
		else $error("nonfatal message missing");
	no_cause_a: assert property (live == 32'h0 |=> !ERR_FATAL_SEND && !ERR_NONFATAL_SEND)
		else $error("message without unmasked error");
	reserved_zero_a: assert property ((severity & ~sec_err_pkg::SEVERITY_WMASK) == 32'h0)
		else $error("reserved severity bit set");
	cap_read_a: assert property (CFG_RD && CFG_ADDR == sec_err_pkg::CAP_CTRL_OFFSET
		|=> CFG_RVALID && CFG_RDATA[31:5] == 27'h0)
		else $error("capability reserved bits nonzero");
	pointer_hold_a: assert property (!lane.load_pointer |=> $stable(first_error_pointer))
		else $error("pointer changed without load");
	pointer_load_a: assert property (lane.load_pointer
		|=> first_error_pointer == $past(lane.pointer_value))
		else $error("pointer not loaded");
	storage_bit_a: assert property (CFG_WR && hits(CFG_ADDR, sec_err_pkg::SEVERITY_OFFSET)
		&& CFG_BE[1] |=> severity[13] == $past(CFG_WDATA[13]))
		else $error("storage bit not written");
	// Severity only moves on a write to its own offset
	severity_hold_a: assert property (!(CFG_WR && hits(CFG_ADDR, sec_err_pkg::SEVERITY_OFFSET))
		|=> $stable(severity))
		else $error("severity changed without write");
	// A disabled byte lane 1 keeps its bits 15:8
	lane_keep_a: assert property (CFG_WR && !CFG_BE[1]
		|=> severity[15:8] == $past(severity[15:8]))
		else $error("disabled byte lane written");
	pcix_quiet_a: assert property ((ERROR_EVENT & sec_err_pkg::REPORTED_MASK) == 32'h0
		|=> !ERR_FATAL_SEND && !ERR_NONFATAL_SEND)
		else $error("message for storage-only error");
	masked_quiet_a: assert property ((ERROR_EVENT & ~ERROR_MASK) == 32'h0
		|=> !ERR_FATAL_SEND && !ERR_NONFATAL_SEND)
		else $error("message for masked error");
	pointer_freeze_a: assert property (status_busy |-> !lane.load_pointer)
		else $error("pointer load while status busy");
	rvalid_pulse_a: assert property (!CFG_RD |=> !CFG_RVALID)
		else $error("read valid without read");
	unmapped_read_a: assert property (CFG_RD && !hits(CFG_ADDR, sec_err_pkg::SEVERITY_OFFSET)
		&& !hits(CFG_ADDR, sec_err_pkg::CAP_CTRL_OFFSET) |=> CFG_RDATA == 32'h0)
		else $error("unmapped read not zero");
	sev_read_a: assert property (CFG_RD && hits(CFG_ADDR, sec_err_pkg::SEVERITY_OFFSET)
		|=> CFG_RDATA[31:14] == 18'h00000 && !CFG_RDATA[4] && !CFG_RDATA[0])
		else $error("reserved severity bits read nonzero");

	fatal_seen_c: cover property (ERR_FATAL_SEND);
	nonfatal_seen_c: cover property (ERR_NONFATAL_SEND);
	pointer_load_c: cover property (lane.load_pointer);
	pointer_freeze_c: cover property (status_busy && |live);
	lane_write_c: cover property (CFG_WR && CFG_BE != 4'hF);
endmodule : secondary_error_severity_pointer
`default_nettype wire

/* dv/err_msg_sink.sv */
`default_nettype none
module err_msg_sink (
	input  wire logic clk,
	input  wire logic fatal,
	input  wire logic nonfatal,
	output int        n_fatal,
	output int        n_nonfatal
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		n_fatal = 0;
		n_nonfatal = 0;
	end
	// Upstream port only tallies each message kind
	always @(posedge clk) begin
		n_fatal <= n_fatal + int'(fatal === 1'h1);
		n_nonfatal <= n_nonfatal + int'(nonfatal === 1'h1);
	end
endmodule : err_msg_sink
`default_nettype wire

/* dv/tb_secondary_error_severity_pointer.sv */
`default_nettype none
module tb_secondary_error_severity_pointer;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 0, rst_n = 0, global_reset_input_n = 1, wr = 0, rd = 0, rvalid, fat, nfat;
	logic        link_n = 1;
	logic [3:0]  be = 4'hF;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0, ev = 32'h0, mask = 32'h0, stat = 32'h0, rdata;
	int          mismatches = 0, samples_checked = 0, nf, nn;
	always #5 mclk = ~mclk;
	secondary_error_severity_pointer dut_u (.MCLK(mclk), .RST_N(rst_n),
		.LINK_RESET_INPUT_N(link_n), .GLOBAL_RESET_INPUT_N(global_reset_input_n), .CFG_ADDR(addr),
		.CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wdata), .CFG_BE(be), .ERROR_EVENT(ev),
		.ERROR_MASK(mask), .ERROR_STATUS(stat), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
		.ERR_FATAL_SEND(fat), .ERR_NONFATAL_SEND(nfat));
	err_msg_sink sink_u (.clk(mclk), .fatal(fat), .nonfatal(nfat), .n_fatal(nf),
		.n_nonfatal(nn));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(negedge mclk);
		addr = a;
		wdata = d;
		wr = 1'h1;
		@(negedge mclk);
		wr = 1'h0;
	endtask : wr_reg
	// Answer comes one cycle after the strobe, so a fixed wait suffices
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
		@(negedge mclk);
		addr = a;
		rd = 1'h1;
		@(negedge mclk);
		rd = 1'h0;
		chk("read valid", 32'h1, {31'h0, rvalid});
		chk("read data", e, rdata);
	endtask : rd_reg
	task automatic fire(input int b, input int ef, input int en);
		@(negedge mclk);
		ev[b] = 1'h1;
		@(negedge mclk);
		ev = 32'h0;
		@(negedge mclk);
		chk("fatal count", ef, nf);
		chk("nonfatal count", en, nn);
	endtask : fire
	initial begin
		repeat (5) @(negedge mclk);
		rst_n = 1'h1;
		rd_reg(12'h134, 32'h1340);
		rd_reg(12'h138, 32'h0);
		wr_reg(12'h134, 32'hFFFFFFFF);
		rd_reg(12'h134, 32'h3FEE);
		wr_reg(12'h138, 32'hFFFFFFFF);
		rd_reg(12'h138, 32'h0);
		wr_reg(12'h134, 32'h1000);
		mask = 32'h8;
		fire(3, 0, 0);
		fire(13, 0, 0);
		rd_reg(12'h138, 32'h0);
		fire(12, 1, 0);
		stat = 32'h1000;
		fire(11, 1, 1);
		rd_reg(12'h138, 32'hC);
		global_reset_input_n = 1'h0;
		@(negedge mclk);
		global_reset_input_n = 1'h1;
		rd_reg(12'h134, 32'h1340);
		rd_reg(12'h138, 32'h0);
		be = 4'h2;
		wr_reg(12'h134, 32'h0);
		be = 4'hF;
		rd_reg(12'h134, 32'h40);
		link_n = 1'h0;
		@(negedge mclk);
		link_n = 1'h1;
		rd_reg(12'h134, 32'h1340);
		mask = 32'h0;
		stat = 32'h0;
		@(negedge mclk);
		ev = 32'h84;
		@(negedge mclk);
		ev = 32'h0;
		@(negedge mclk);
		chk("fatal count", 32'd1, nf);
		chk("nonfatal count", 32'd2, nn);
		rd_reg(12'h138, 32'h2);
		wrap_up();
	end
endmodule : tb_secondary_error_severity_pointer
`default_nettype wire
